// *** logic/sdec_pkg.sv ***
/*
  Shared constants and carrier types for the servo drive enable control block.
  Assumes a single 100 MHz clock domain and a host command decoder upstream.
*/
package sdec_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYC        = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ID_SETTLE_CYC = 4;

  // ==========================================================
  // Widths, reset values and codes
  localparam int         UNIT_ID_W     = 5;
  localparam int         UNIT_ID_MIN   = 1;
  localparam int         UNIT_ID_MAX   = 32;
  localparam logic       DRV_EN_RST    = 1'b0;
  localparam logic [7:0] ERR_NONE      = 8'h00;
  localparam logic [7:0] ERR_DRIVE_OFF = 8'h87;

  // ==========================================================
  // Command codes: spelled-out and abbreviated forms are separate codes.
  typedef enum logic [3:0] {
    C_NONE      = 4'b0000,
    C_DRV_FULL  = 4'b0001,
    C_DRV_ABBR  = 4'b0010,
    C_MOTION_COMPLETE_WAIT  = 4'b0011,
    C_WAIT      = 4'b0100,
    C_UNIT      = 4'b0101,
    C_MOVE_FULL = 4'b0110,
    C_MOVE_ABBR = 4'b0111
  } sdec_code_t;

  typedef enum logic [2:0] {
    OP_NONE   = 3'b000,
    OP_DRV    = 3'b001,
    OP_WDONE  = 3'b010,
    OP_WTIME  = 3'b011,
    OP_UNIT   = 3'b100,
    OP_MOVE   = 3'b101
  } sdec_op_t;

  typedef struct packed {
    logic        valid;
    sdec_code_t  code;
    logic        wr;
    logic        prog;
    logic        esc;
    logic        locked;
    logic [31:0] arg;
  } sdec_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } sdec_rsp_t;

  typedef struct packed {
    logic        integ_clear;
    logic        out_zero;
    logic        pos_load;
    logic [31:0] pos;
  } sdec_loop_t;

endpackage : sdec_pkg

// *** logic/sdec_sync3.sv ***
/*
  Three-stage synchroniser for a bus of slow switch inputs.
  Assumes the inputs change rarely; stable is high while stages two and three agree.
*/
`timescale 1ns/100ps
module sdec_sync3 #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout,
  output logic              stable
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // A zero-width bus has nothing to carry.
  generate
    if (W < 1)
    begin : g_bad_width
      $error("W must be at least one bit");
    end
  endgenerate

  // ==========================================================
  // Pipeline
  // Stage one only feeds stage two so a metastable bit never reaches a compare.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A value counts once two clean stages agree.
  assign dout   = s3_q;
  assign stable = (s2_q == s3_q);

endmodule : sdec_sync3

// *** logic/sdec_ctrl.sv ***
/*
  Servo drive enable and command gating: unit id capture, drive enable with
  motion interlock, loop clear and position alignment, move gating, pauses.
  Assumes a decoded command stream on the same clock and a motion engine that
  raises motion_busy within one cycle of motion_start.
*/
`timescale 1ns/100ps
module sdec_ctrl #(
  parameter int MS_TICK_CYC = sdec_pkg::MS_CYC
) (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic [sdec_pkg::UNIT_ID_W-1:0]   unit_id_sw,
  input  wire sdec_pkg::sdec_cmd_t              cmd,
  input  wire logic                             prog_running,
  input  wire logic                             motion_busy,
  input  wire logic [31:0]                      encoder_position,
  output sdec_pkg::sdec_rsp_t                   rsp,
  output sdec_pkg::sdec_loop_t                  loop_ctl,
  output logic                                  drive_enable,
  output logic                                  drive_enable_pending,
  output logic                                  motion_start,
  output logic                                  err_set,
  output logic [7:0]                            err_code,
  output logic                                  prog_hold
);
  import sdec_pkg::*;

  generate
    if (MS_TICK_CYC < 1)
    begin : g_bad_tick
      $error("MS_TICK_CYC must be at least one cycle");
    end
  endgenerate

  // ==========================================================
  // Command decode
  // Both spellings of a command map to one operation.
  function automatic sdec_op_t op_of(input sdec_code_t c);
    unique case (c)
      C_DRV_FULL,  C_DRV_ABBR:  op_of = OP_DRV;
      C_MOVE_FULL, C_MOVE_ABBR: op_of = OP_MOVE;
      C_MOTION_COMPLETE_WAIT:               op_of = OP_WDONE;
      C_WAIT:                   op_of = OP_WTIME;
      C_UNIT:                   op_of = OP_UNIT;
      default:                  op_of = OP_NONE;
    endcase
  endfunction : op_of

  typedef enum logic [1:0] {
    EX_RUN   = 2'b00,
    EX_TIME  = 2'b01,
    EX_DONE  = 2'b10
  } sdec_ex_t;

  sdec_op_t                 op;
  logic                     host_ok;
  logic                     take;
  logic                     drv_wr;
  logic                     drv_rd;
  logic                     mv_req;
  logic                     id_stable;
  logic [UNIT_ID_W-1:0]     id_sync;
  logic                     apply;

  logic                     drv_q;
  logic                     drv_d;
  logic                     pend_q;
  logic                     pend_d;
  logic [5:0]               id_q;
  logic                     id_taken_q;
  logic [2:0]               settle_q;
  logic [31:0]              tick_q;
  logic [31:0]              ms_q;
  sdec_ex_t                 ex_q;
  sdec_ex_t                 ex_d;
  sdec_rsp_t                rsp_q;
  logic                     load_q;
  logic [31:0]              pos_q;
  logic                     start_q;
  logic                     eset_q;
  logic [7:0]               err_q;

  // Host commands during a program need the escape prefix and must not be locked.
  assign host_ok = !prog_running || (cmd.esc && !cmd.locked);
  assign op      = op_of(cmd.code);
  assign take    = cmd.valid && (cmd.prog || host_ok);
  assign drv_wr  = take && (op == OP_DRV) && cmd.wr;
  assign drv_rd  = take && (op == OP_DRV) && !cmd.wr;
  assign mv_req  = take && (op == OP_MOVE);

  // ==========================================================
  // Unit id capture
  sdec_sync3 #(
    .W      (UNIT_ID_W)
  ) u_id_sync (
    .clk    (clk),
    .rst    (rst),
    .din    (unit_id_sw),
    .dout   (id_sync),
    .stable (id_stable)
  );

  // The switches are read once only; later changes are ignored until reset.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      settle_q   <= '0;
      id_taken_q <= 1'b0;
      id_q       <= 6'(UNIT_ID_MIN);
    end
    else if (!id_taken_q)
    begin
      if (settle_q != 3'(ID_SETTLE_CYC))
        settle_q <= settle_q + 3'h1;
      else if (id_stable)
      begin
        id_taken_q <= 1'b1;
        id_q       <= {1'b0, id_sync} + 6'h01;
      end
    end
  end

  // ==========================================================
  // Drive enable with motion interlock
  // A negative value is treated as off; the host keeps to zero or positive.
  assign pend_d = drv_wr ? (cmd.arg != 32'h0 && !cmd.arg[31]) : pend_q;
  // Applied only with no motion, so a held request lands when busy drops.
  assign apply  = !motion_busy;
  assign drv_d  = apply ? pend_d : drv_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pend_q <= DRV_EN_RST;
      drv_q  <= DRV_EN_RST;
    end
    else
    begin
      pend_q <= pend_d;
      drv_q  <= drv_d;
    end
  end

  // Position alignment rides on the enable edge so no jump reaches the loop.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      load_q <= 1'b0;
      pos_q  <= '0;
    end
    else
    begin
      load_q <= drv_d && !drv_q;
      if (drv_d && !drv_q)
        pos_q <= encoder_position;
    end
  end

  // ==========================================================
  // Move gating and error code
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      start_q <= 1'b0;
      eset_q  <= 1'b0;
      err_q   <= ERR_NONE;
    end
    else
    begin
      start_q <= mv_req && drv_q;
      eset_q  <= mv_req && !drv_q;
      if (mv_req && !drv_q)
        err_q <= ERR_DRIVE_OFF;
    end
  end

  // ==========================================================
  // Program pauses
  always_comb
  begin
    ex_d = ex_q;
    unique case (ex_q)
      EX_RUN:
        if (take && cmd.prog && op == OP_WTIME && cmd.arg != 32'h0)
          ex_d = EX_TIME;
        else if (take && cmd.prog && op == OP_WDONE && motion_busy)
          ex_d = EX_DONE;
      EX_TIME:
        if (ms_q == 32'h1 && tick_q == 32'(MS_TICK_CYC - 1))
          ex_d = EX_RUN;
      EX_DONE:
        if (!motion_busy)
          ex_d = EX_RUN;
      default:
        ex_d = EX_RUN;
    endcase
  end

  // Millisecond counter; a zero-length pause never leaves the run state.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ex_q   <= EX_RUN;
      tick_q <= '0;
      ms_q   <= '0;
    end
    else
    begin
      ex_q <= ex_d;
      if (ex_q == EX_RUN)
      begin
        tick_q <= '0;
        ms_q   <= cmd.arg;
      end
      else if (tick_q == 32'(MS_TICK_CYC - 1))
      begin
        tick_q <= '0;
        ms_q   <= ms_q - 32'h1;
      end
      else
        tick_q <= tick_q + 32'h1;
    end
  end

  // ==========================================================
  // Read answers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rsp_q <= '0;
    else
    begin
      rsp_q.valid <= drv_rd || (take && op == OP_UNIT);
      rsp_q.data  <= drv_rd ? {31'h0, drv_q} : {26'h0, id_q};
    end
  end

  // ==========================================================
  // Outputs
  // Loop clear is a level so the loop cannot wind up while the drive is off.
  assign loop_ctl.integ_clear = !drv_q;
  assign loop_ctl.out_zero    = !drv_q;
  assign loop_ctl.pos_load    = load_q;
  assign loop_ctl.pos         = pos_q;
  assign drive_enable         = drv_q;
  assign drive_enable_pending = pend_q;
  assign motion_start         = start_q;
  assign err_set              = eset_q;
  assign err_code             = err_q;
  assign prog_hold            = (ex_q != EX_RUN);
  assign rsp                  = rsp_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_drive_busy_hold: assert property (drive_enable != $past(drive_enable) |-> !$past(motion_busy))
    else $error("drive enable changed during motion");
  a_drive_on_cause: assert property ($rose(drive_enable) |-> $past(pend_d))
    else $error("drive enable rose without an on request");
  a_pend_apply: assert property (!motion_busy && pend_q != drive_enable && !drv_wr |=> drive_enable == $past(pend_q))
    else $error("pending enable not applied after motion");
  a_loop_zeroed: assert property (!drive_enable |-> loop_ctl.integ_clear && loop_ctl.out_zero)
    else $error("loop not cleared while drive off");
  a_pos_align: assert property ($rose(drive_enable) |-> loop_ctl.pos_load && loop_ctl.pos == $past(encoder_position))
    else $error("position not aligned on enable");
  a_move_error: assert property (mv_req && !drive_enable |=> err_set && err_code == ERR_DRIVE_OFF && !motion_start)
    else $error("move while disabled not refused");
  a_read_state: assert property (drv_rd |=> rsp.valid && rsp.data == {31'h0, $past(drive_enable)})
    else $error("enable state read wrong");
  a_unit_range: assert property (id_taken_q |-> rsp_q.data <= 32'h20 && id_q >= 6'h01 && id_q <= 6'h20)
    else $error("unit id out of range");
  a_no_esc_drop: assert property (cmd.valid && !cmd.prog && prog_running && !cmd.esc |-> !take)
    else $error("unescaped host command taken during program");
  a_done_hold: assert property (ex_q == EX_DONE && motion_busy |=> prog_hold)
    else $error("motion wait released while busy");
  a_done_release: assert property (ex_q == EX_DONE && !motion_busy |=> !prog_hold)
    else $error("motion wait not released");

  c_enable_on:   cover property ($rose(drive_enable));
  c_pend_during: cover property (motion_busy && pend_q != drive_enable ##[1:50] drive_enable == pend_q);
  c_move_refuse: cover property (err_set);
  c_time_pause:  cover property ($rose(prog_hold) && ex_q == EX_TIME);

endmodule : sdec_ctrl

// *** tb/sdec_host_model.sv ***
/*
  Host computer model: issues one-cycle commands to the drive enable block.
  Assumes the bench calls send from its main sequence on the block clock.
*/
`timescale 1ns/100ps
module sdec_host_model
  import sdec_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           prog_running,
  output sdec_pkg::sdec_cmd_t cmd
);
  // ==========================================================
  // Command issue
  // The strobe is idle until the bench asks for a command.
  initial cmd = '0;

  // One strobe per command; the host never sends a negative drive value.
  // The escape prefix is added while a program runs, unless the bench asks for a bare command.
  task automatic send(input sdec_code_t c, input logic wr, prog, bare, lock, input logic [31:0] a);
    @(posedge clk);
    cmd <= '{1'b1, c, wr, prog, prog_running & !bare, lock, {1'b0, a[30:0]}};
    @(posedge clk);
    cmd.valid <= 1'b0;
  endtask : send
endmodule : sdec_host_model

// *** tb/servo_drive_enable_control_tb_top.sv ***
/*
  Self-checking bench for the drive enable block against a small behavioural model.
  Assumes the block is built with a four-cycle millisecond tick.
*/
`timescale 1ns/100ps
module servo_drive_enable_control_tb_top;
  import sdec_pkg::*;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic [UNIT_ID_W-1:0] sw;
  logic                 prog_running = 1'b0;
  logic                 motion_busy = 1'b0;
  logic [31:0]          enc;
  sdec_cmd_t            cmd;
  sdec_rsp_t            rsp;
  sdec_loop_t           lc;
  logic                 de, dep, ms, es, ph;
  logic [7:0]           ec;
  int                   miscompares = 0;
  int                   n_tests = 0;
  int                   seed = 32'h47eb;
  int                   m_drv = 0;
  int                   m_err = 0;
  int                   m_id;
  int                   n;
  int                   q_rd[$];
  localparam int        TICK = 4;
  sdec_code_t           mv[2] = '{C_MOVE_FULL, C_MOVE_ABBR};

  // ==========================================================
  // Clock, block and host
  always #5 clk = ~clk;

  sdec_ctrl #(.MS_TICK_CYC(TICK)) sdec_ctrl_inst (.clk(clk), .rst(rst), .unit_id_sw(sw), .cmd(cmd),
    .prog_running(prog_running), .motion_busy(motion_busy), .encoder_position(enc), .rsp(rsp),
    .loop_ctl(lc), .drive_enable(de), .drive_enable_pending(dep), .motion_start(ms),
    .err_set(es), .err_code(ec), .prog_hold(ph));

  sdec_host_model sdec_host_model_inst (.clk(clk), .prog_running(prog_running), .cmd(cmd));

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // Results are read 1 ns after the edge so that the edge's updates have landed.
  task automatic host(input sdec_code_t c, input logic wr, prog, bare, lock, input logic [31:0] a);
    sdec_host_model_inst.send(c, wr, prog, bare, lock, a);
    #1;
  endtask : host

  task automatic wait_hold(input logic lvl, input int lim);
    n = 0;
    while (ph !== lvl && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (ph !== lvl)
    begin
      miscompares++;
      wrap_up();
    end
  endtask : wait_hold

  // ==========================================================
  // Main sequence
  initial
  begin
    sw = 5'($random(seed));
    enc = $random(seed);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
    chk("drive_enable", de, 0);
    chk("integ_clear", lc.integ_clear, 1);
    chk("out_zero", lc.out_zero, 1);
    // The switches move after capture; the reported id must not follow them.
    m_id = int'(sw) + 1;
    @(posedge clk);
    sw <= ~sw;
    q_rd.push_back(m_id);
    host(C_UNIT, 0, 0, 0, 0, 0);
    chk("unit_id", rsp.data, q_rd.pop_front());
    foreach (mv[i])
    begin
      host(mv[i], 0, 0, 0, 0, 0);
      m_err = 135;
      chk("motion_start", ms, 0);
      chk("err_set", es, 1);
      chk("err_code", ec, m_err);
    end
    // Both spellings of the drive command: on, read back, off.
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      enc <= $random(seed);
      host(i ? C_DRV_ABBR : C_DRV_FULL, 1, 0, 0, 0, 1);
      m_drv = 1;
      chk("drive_enable", de, m_drv);
      chk("pos_load", lc.pos_load, 1);
      chk("pos", lc.pos, enc);
      chk("integ_clear", lc.integ_clear, 0);
      q_rd.push_back(m_drv);
      host(i ? C_DRV_ABBR : C_DRV_FULL, 0, 0, 0, 0, 0);
      chk("drive_read", rsp.data, q_rd.pop_front());
      chk("rsp_valid", rsp.valid, 1);
      host(i ? C_DRV_FULL : C_DRV_ABBR, 1, 0, 0, 0, 0);
      m_drv = 0;
      chk("drive_enable", de, m_drv);
      chk("out_zero", lc.out_zero, 1);
    end
    q_rd.push_back(m_drv);
    host(C_DRV_FULL, 0, 0, 0, 0, 0);
    chk("drive_read", rsp.data, q_rd.pop_front());
    host(C_DRV_FULL, 1, 0, 0, 0, 1);
    foreach (mv[i])
    begin
      host(mv[i], 0, 0, 0, 0, 0);
      chk("motion_start", ms, 1);
      chk("err_set", es, 0);
    end
    // Off during motion waits for the motion to end.
    @(posedge clk);
    motion_busy <= 1'b1;
    host(C_DRV_FULL, 1, 0, 0, 0, 0);
    chk("pending", dep, 0);
    repeat (3) @(posedge clk);
    #1;
    chk("drive_enable", de, 1);
    @(posedge clk);
    motion_busy <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("drive_enable", de, 0);
    // Gating while a program runs: bare and locked commands are dropped.
    @(posedge clk);
    prog_running <= 1'b1;
    host(C_DRV_FULL, 1, 0, 1, 0, 1);
    chk("drive_enable", de, 0);
    host(C_DRV_ABBR, 1, 0, 0, 1, 1);
    chk("drive_enable", de, 0);
    @(posedge clk);
    prog_running <= 1'b0;
    host(C_DRV_ABBR, 1, 0, 0, 1, 1);
    chk("drive_enable", de, 1);
    @(posedge clk);
    prog_running <= 1'b1;
    host(C_DRV_FULL, 1, 0, 0, 0, 0);
    chk("drive_enable", de, 0);
    // Timed pause of two ticks, then a motion wait.
    host(C_WAIT, 0, 1, 0, 0, 2);
    chk("prog_hold", ph, 1);
    wait_hold(0, 20);
    chk("pause_len", n, 2 * TICK);
    @(posedge clk);
    motion_busy <= 1'b1;
    host(C_MOTION_COMPLETE_WAIT, 0, 1, 0, 0, 0);
    chk("prog_hold", ph, 1);
    repeat (5) @(posedge clk);
    #1;
    chk("prog_hold", ph, 1);
    @(posedge clk);
    motion_busy <= 1'b0;
    #1;
    wait_hold(0, 3);
    chk("prog_hold", ph, 0);
    chk("done_len", n, 1);
    // A motion wait with no motion running must not hold the program.
    host(C_MOTION_COMPLETE_WAIT, 0, 1, 0, 0, 0);
    chk("prog_hold", ph, 0);
    wrap_up();
  end

  // A hang is cut short and counted as a mismatch.
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
endmodule : servo_drive_enable_control_tb_top
